//--- core/tpc_channel.sv
// one capture/compare/pwm channel of a 16-bit timer with byte registers
// assumes a shared counter, its tick, wrap and direction on clk
//
// Contract
// - edge/level 00 detaches the channel from its pin in every mode.
// - capture mode stores the counter on rising, falling or either edge.
// - compare mode leaves, toggles, clears or sets the pin on a match.
// - edge pwm gives high-true pulses for 10 and low-true for x1.
// - center pwm clears (10) or sets (x1) the output on an up match.
// - the value register holds captures and serves as the match value.
// - both value bytes are zero after reset.
// - in capture a byte read freezes the pair until the other is read.
// - a status/control write releases the read freeze.
// - compare byte writes are buffered and loaded only as a pair.
// - a status/control write discards a half-written compare value.
// - the paired write works in either byte order.
// - the flag clears by read while set then write 0; events win.
// - an interrupt is requested while flag and enable are both set.
`timescale 1ns/1ps
`include "tpc_consts.svh"

module tpc_channel (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`TPC_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [7:0]             rdata,
  input  wire logic [15:0]            cnt_value,
  input  wire logic                   cnt_tick,
  input  wire logic                   cnt_wrap,
  input  wire logic                   cnt_up,
  input  wire logic                   center_pwm_select,
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe,
  output logic                        pin_detached,
  output logic                        irq
);

  function automatic tpc_pkg::tpc_mode_t decode_mode(
    input logic       cpwm,
    input logic [1:0] ms
  );
    return cpwm  ? tpc_pkg::tpc_mode_cpwm :
           ms[1] ? tpc_pkg::tpc_mode_epwm :
           ms[0] ? tpc_pkg::tpc_mode_oc   : tpc_pkg::tpc_mode_cap;
  endfunction

  function automatic logic [7:0] sel_byte(
    input logic [15:0] v,
    input logic        hi
  );
    return hi ? v[15:8] : v[7:0];
  endfunction

  logic                   flag_q, flag_d;
  logic                   ie_q, ie_d;
  logic [1:0]             ms_q, ms_d;
  logic [1:0]             els_q, els_d;
  logic                   arm_q, arm_d;
  logic [15:0]            val_q, val_d;
  logic [15:0]            rbuf_q, rbuf_d;
  logic                   latch_q, latch_d;
  logic                   latch_hi_q, latch_hi_d;
  logic [7:0]             wbuf_hi_q, wbuf_hi_d;
  logic [7:0]             wbuf_lo_q, wbuf_lo_d;
  logic                   have_hi_q, have_hi_d;
  logic                   have_lo_q, have_lo_d;
  logic [`TPC_EV_W-1:0]   stat_q, stat_d;
  logic [`TPC_EV_W-1:0]   en_q, en_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   irq_q, irq_d;
  logic                   pin_q, pin_d;
  logic                   oe_q, oe_d;
  logic                   det_q, det_d;

  logic                   pin_rise;
  logic                   pin_fall;
  tpc_pkg::tpc_mode_t     mode;
  logic                   is_cap;
  logic                   is_out;
  logic                   cap_edge;
  logic                   match;
  logic                   event_any;
  logic [`TPC_EV_W-1:0]   ev_vec;
  logic                   rd_sc, rd_vh, rd_vl, rd_stat, rd_en;
  logic                   wr_sc, wr_vh, wr_vl, wr_clr, wr_en;
  logic [7:0]             sc_view;

  tpc_pin_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .pin_raw (pin_in),
    .level   (),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  assign mode   = decode_mode(center_pwm_select, ms_q);
  assign is_cap = (mode == tpc_pkg::tpc_mode_cap);
  assign is_out = ~is_cap;

  // a stale edge from before the mode switch can still land here
  assign cap_edge = is_cap & ((els_q[0] & pin_rise) |
                              (els_q[1] & pin_fall));
  assign match    = is_out & cnt_tick & (cnt_value == val_q);
  assign event_any = cap_edge | match;

  always_comb begin
    ev_vec = `TPC_EV_RST;
    ev_vec[`TPC_EV_CAP] = cap_edge;
    ev_vec[`TPC_EV_CMP] = match;
  end

  assign rd_sc   = rd & (addr == `TPC_ADDR_SC);
  assign rd_vh   = rd & (addr == `TPC_ADDR_VH);
  assign rd_vl   = rd & (addr == `TPC_ADDR_VL);
  assign rd_stat = rd & (addr == `TPC_ADDR_STAT);
  assign rd_en   = rd & (addr == `TPC_ADDR_EN);
  assign wr_sc   = wr & (addr == `TPC_ADDR_SC);
  assign wr_vh   = wr & (addr == `TPC_ADDR_VH);
  assign wr_vl   = wr & (addr == `TPC_ADDR_VL);
  assign wr_clr  = wr & (addr == `TPC_ADDR_CLR);
  assign wr_en   = wr & (addr == `TPC_ADDR_EN);

  assign sc_view = {flag_q, ie_q, ms_q, els_q, 2'h0};

  // register file, value path and flag
  always_comb begin
    flag_d     = flag_q;
    ie_d       = ie_q;
    ms_d       = ms_q;
    els_d      = els_q;
    arm_d      = arm_q;
    val_d      = val_q;
    rbuf_d     = rbuf_q;
    latch_d    = latch_q;
    latch_hi_d = latch_hi_q;
    wbuf_hi_d  = wbuf_hi_q;
    wbuf_lo_d  = wbuf_lo_q;
    have_hi_d  = have_hi_q;
    have_lo_d  = have_lo_q;
    en_d       = en_q;
    rdata_d    = `TPC_BYTE_RST;
    if (cap_edge)
      val_d = cnt_value;
    if (rd_sc) begin
      rdata_d = sc_view;
      if (flag_q)
        arm_d = 1'b1;
    end
    if (wr_sc) begin
      ie_d      = wdata[`TPC_SC_IE];
      ms_d      = wdata[`TPC_SC_MSH:`TPC_SC_MSL];
      els_d     = wdata[`TPC_SC_ELS_HI:`TPC_SC_ELS_LO];
      latch_d   = 1'b0;
      have_hi_d = 1'b0;
      have_lo_d = 1'b0;
      if (arm_q && !wdata[`TPC_SC_FLAG])
        flag_d = 1'b0;
      arm_d = 1'b0;
    end
    // a new event restarts the clear sequence and keeps the flag
    if (event_any) begin
      flag_d = 1'b1;
      arm_d  = 1'b0;
    end
    if (rd_vh || rd_vl) begin
      if (is_cap && latch_q) begin
        rdata_d = sel_byte(rbuf_q, rd_vh);
        if (rd_vh != latch_hi_q)
          latch_d = 1'b0;
      end else begin
        rdata_d = sel_byte(val_q, rd_vh);
        if (is_cap) begin
          latch_d    = 1'b1;
          latch_hi_d = rd_vh;
          rbuf_d     = val_q;
        end
      end
    end
    // writes in capture mode are dropped; the live capture owns val
    if (wr_vh && is_out) begin
      wbuf_hi_d = wdata;
      have_hi_d = 1'b1;
    end
    if (wr_vl && is_out) begin
      wbuf_lo_d = wdata;
      have_lo_d = 1'b1;
    end
    if (have_hi_d && have_lo_d) begin
      val_d     = {wbuf_hi_d, wbuf_lo_d};
      have_hi_d = 1'b0;
      have_lo_d = 1'b0;
    end
    if (rd_stat)
      rdata_d = {6'h00, stat_q};
    if (rd_en)
      rdata_d = {6'h00, en_q};
    if (wr_en)
      en_d = wdata[`TPC_EV_W-1:0];
  end

  // sticky events; a clear in the event's own cycle loses
  always_comb begin
    stat_d = stat_q;
    if (wr_clr)
      stat_d = stat_d & ~wdata[`TPC_EV_W-1:0];
    stat_d = stat_d | ev_vec;
    irq_d  = (|(stat_d & en_d)) | (flag_d & ie_d);
  end

  // pin drive
  always_comb begin
    pin_d = pin_q;
    det_d = (els_q == `TPC_ELS_OFF);
    oe_d  = is_out & ~det_d;
    case (mode)
      tpc_pkg::tpc_mode_oc: begin
        if (match) begin
          case (els_q)
            `TPC_ELS_TOGGLE: pin_d = ~pin_q;
            `TPC_ELS_CLEAR:  pin_d = 1'b0;
            `TPC_ELS_SET:    pin_d = 1'b1;
            default:         pin_d = pin_q;
          endcase
        end
      end
      tpc_pkg::tpc_mode_epwm: begin
        // match beats wrap so a zero value gives zero duty
        if (cnt_wrap)
          pin_d = (els_q == `TPC_ELS_CLEAR);
        if (match)
          pin_d = (els_q != `TPC_ELS_CLEAR);
      end
      tpc_pkg::tpc_mode_cpwm: begin
        if (match)
          pin_d = (els_q == `TPC_ELS_CLEAR) ? ~cnt_up : cnt_up;
      end
      tpc_pkg::tpc_mode_cap: pin_d = pin_q;
      default:               pin_d = pin_q;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q     <= 1'b0;
      ie_q       <= 1'b0;
      ms_q       <= `TPC_FIELD_RST;
      els_q      <= `TPC_FIELD_RST;
      arm_q      <= 1'b0;
      val_q      <= `TPC_VAL_RST;
      rbuf_q     <= `TPC_VAL_RST;
      latch_q    <= 1'b0;
      latch_hi_q <= 1'b0;
      wbuf_hi_q  <= `TPC_BYTE_RST;
      wbuf_lo_q  <= `TPC_BYTE_RST;
      have_hi_q  <= 1'b0;
      have_lo_q  <= 1'b0;
      stat_q     <= `TPC_EV_RST;
      en_q       <= `TPC_EV_RST;
      rdata_q    <= `TPC_BYTE_RST;
      irq_q      <= 1'b0;
      pin_q      <= 1'b0;
      oe_q       <= 1'b0;
      det_q      <= 1'b1;
    end else begin
      flag_q     <= flag_d;
      ie_q       <= ie_d;
      ms_q       <= ms_d;
      els_q      <= els_d;
      arm_q      <= arm_d;
      val_q      <= val_d;
      rbuf_q     <= rbuf_d;
      latch_q    <= latch_d;
      latch_hi_q <= latch_hi_d;
      wbuf_hi_q  <= wbuf_hi_d;
      wbuf_lo_q  <= wbuf_lo_d;
      have_hi_q  <= have_hi_d;
      have_lo_q  <= have_lo_d;
      stat_q     <= stat_d;
      en_q       <= en_d;
      rdata_q    <= rdata_d;
      irq_q      <= irq_d;
      pin_q      <= pin_d;
      oe_q       <= oe_d;
      det_q      <= det_d;
    end
  end

  assign rdata        = rdata_q;
  assign irq          = irq_q;
  assign pin_out      = pin_q;
  assign pin_oe       = oe_q;
  assign pin_detached = det_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_latch_hi;
    rd_vh && is_cap && !latch_q;
  endsequence
  sequence s_quiet;
    !wr_sc && !rd_vh && !rd_vl;
  endsequence
  sequence s_arm;
    rd_sc && flag_q && !event_any;
  endsequence
  chk_pin_detach: assert property (
    (els_q == `TPC_ELS_OFF) |=> !pin_oe && pin_detached)
    else $error("pin driven while edge/level is 00");
  chk_cap_rise: assert property (
    (is_cap && els_q == `TPC_ELS_TOGGLE && pin_rise)
      |=> flag_q && val_q == $past(cnt_value))
    else $error("rising edge not captured");
  chk_cap_ignore: assert property (
    (is_cap && els_q == `TPC_ELS_TOGGLE && pin_fall && !rd && !wr)
      |=> $stable(val_q))
    else $error("falling edge captured in rising-only mode");
  chk_oc_toggle: assert property (
    (mode == tpc_pkg::tpc_mode_oc && els_q == `TPC_ELS_TOGGLE && match)
      |=> pin_out != $past(pin_out))
    else $error("compare match did not toggle pin");
  chk_epwm_clear: assert property (
    (mode == tpc_pkg::tpc_mode_epwm && els_q == `TPC_ELS_CLEAR && match)
      |=> !pin_out)
    else $error("high-true pwm not cleared on match");
  chk_cpwm_up: assert property (
    (mode == tpc_pkg::tpc_mode_cpwm && els_q[0] && match && cnt_up)
      |=> pin_out)
    else $error("low-true center pwm not set on up match");
  chk_rd_freeze: assert property (
    s_latch_hi ##1 s_quiet |=> latch_q && rbuf_q == $past(val_q, 2))
    else $error("read latch lost its pair");
  chk_latch_release: assert property (
    wr_sc |=> !latch_q)
    else $error("control write left read latch set");
  chk_pair_load: assert property (
    (have_lo_q && wr_vh && is_out && !wr_sc)
      |=> val_q == {$past(wdata), $past(wbuf_lo_q)})
    else $error("low-then-high write not loaded");
  chk_half_hold: assert property (
    (wr_vh && is_out && !have_lo_q) |=> $stable(val_q))
    else $error("single byte changed the compare value");
  chk_wr_discard: assert property (
    wr_sc |=> !have_hi_q && !have_lo_q)
    else $error("control write kept a half compare value");
  // the bus may leave an idle cycle between the arming read and the write
  chk_flag_clear: assert property (
    s_arm ##1 (!wr_sc && !event_any)
      ##1 (wr_sc && !wdata[`TPC_SC_FLAG] && !event_any) |=> !flag_q)
    else $error("flag not cleared by read then write 0");
  chk_irq_level: assert property (
    (flag_q && ie_q) |-> irq)
    else $error("no interrupt with flag and enable set");
  chk_match_tick: assert property (
    (!cnt_tick && !stat_q[`TPC_EV_CMP]) |=> !stat_q[`TPC_EV_CMP])
    else $error("compare event without counter advance");

endmodule

//--- core/tpc_consts.svh
// register offsets, field positions and reset values of one timer channel
// assumes the includer compiles it once per unit; guarded anyway
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

`define TPC_ADDR_W      3
`define TPC_ADDR_SC     3'h0
`define TPC_ADDR_VH     3'h1
`define TPC_ADDR_VL     3'h2
`define TPC_ADDR_STAT   3'h3
`define TPC_ADDR_CLR    3'h4
`define TPC_ADDR_EN     3'h5

`define TPC_SC_FLAG     7
`define TPC_SC_IE       6
`define TPC_SC_MSH      5
`define TPC_SC_MSL      4
`define TPC_SC_ELS_HI   3
`define TPC_SC_ELS_LO   2

`define TPC_ELS_OFF     2'h0
`define TPC_ELS_TOGGLE  2'h1
`define TPC_ELS_CLEAR   2'h2
`define TPC_ELS_SET     2'h3

`define TPC_EV_CAP      0
`define TPC_EV_CMP      1
`define TPC_EV_W        2

`define TPC_VAL_RST     16'h0000
`define TPC_BYTE_RST    8'h00
`define TPC_EV_RST      2'h0
`define TPC_FIELD_RST   2'h0

`endif

//--- core/tpc_pkg.sv
// types shared by the timer channel files
// assumes tpc_consts.svh is compiled alongside for the numbers
package tpc_pkg;

  typedef enum logic [3:0] {
    tpc_mode_cap  = 4'b0001,
    tpc_mode_oc   = 4'b0010,
    tpc_mode_epwm = 4'b0100,
    tpc_mode_cpwm = 4'b1000
  } tpc_mode_t;

endpackage

//--- core/tpc_pin_sync.sv
// two-flop synchroniser and edge detector for the channel pin
// assumes pin_raw is asynchronous to clk
`timescale 1ns/1ps

module tpc_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_raw,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_q;
  logic s1_d;
  logic s2_q;
  logic s2_d;
  logic s3_q;
  logic s3_d;

  // s1 feeds only s2; edges come from s2 against s3
  always_comb begin
    s1_d = pin_raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;

endmodule

//--- testbench/tpc_pin_model.sv
// far side of the channel pin: an outside signal source
// assumes the bench sets the wanted level just after a clock edge
`timescale 1ns/1ps
module tpc_pin_model (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_in
);
  initial pin_in = 1'b0;
  // moves only after an edge and then stays put, so capture
  // is never entered on a pin that is still settling
  always @(posedge clk) begin
    pin_in <= pin_oe ? pin_out : want;
  end
endmodule

//--- testbench/testbench.sv
// self-checking bench: bus, counter and pin scenarios
// assumes the pin model and the channel design are compiled first
`timescale 1ns/1ps
`include "tpc_consts.svh"
module testbench;
  logic [`TPC_ADDR_W-1:0] addr;
  logic [15:0]            cnt_value;
  logic [7:0]             wdata;
  logic [7:0]             rdata;
  logic                   clk;
  logic                   rst;
  logic                   wr;
  logic                   rd;
  logic                   cnt_tick;
  logic                   cnt_wrap;
  logic                   cnt_up;
  logic                   cps;
  logic                   want;
  logic                   pin_in;
  logic                   pin_out;
  logic                   pin_oe;
  logic                   pin_detached;
  logic                   irq;
  int                     n_mismatch;
  int                     checks_done;

  tpc_channel dut (
    .clk               (clk),
    .rst               (rst),
    .addr              (addr),
    .wdata             (wdata),
    .wr                (wr),
    .rd                (rd),
    .rdata             (rdata),
    .cnt_value         (cnt_value),
    .cnt_tick          (cnt_tick),
    .cnt_wrap          (cnt_wrap),
    .cnt_up            (cnt_up),
    .center_pwm_select (cps),
    .pin_in            (pin_in),
    .pin_out           (pin_out),
    .pin_oe            (pin_oe),
    .pin_detached      (pin_detached),
    .irq               (irq)
  );

  tpc_pin_model pin_side (
    .clk     (clk),
    .want    (want),
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .pin_in  (pin_in)
  );

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr_r(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand one cycle only, so look right after the edge
  task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                     input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask

  task automatic tk(input logic [15:0] v, input logic up, w, t);
    @(posedge clk);
    cnt_value <= v;
    cnt_up <= up;
    cnt_wrap <= w;
    cnt_tick <= t;
    @(posedge clk);
    cnt_tick <= 1'b0;
    cnt_wrap <= 1'b0;
    #1;
  endtask

  // 6 cycles covers sync, detect and capture
  task automatic pin(input logic v, input logic [15:0] c);
    @(posedge clk);
    want <= v;
    cnt_value <= c;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset;
    rdc(`TPC_ADDR_VH, 8'h00, "vh rst");
    rdc(`TPC_ADDR_VL, 8'h00, "vl rst");
    chk("det rst", pin_detached, 1'b1);
    chk("irq rst", irq, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_oc;
    logic [1:0] el [5] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h0};
    logic       ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    wr_r(`TPC_ADDR_SC, 8'h1C);
    wr_r(`TPC_ADDR_VH, 8'h12);
    wr_r(`TPC_ADDR_VL, 8'h34);
    tk(16'h1234, 1'b1, 1'b0, 1'b0);
    chk("no tick", pin_out, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr_r(`TPC_ADDR_SC, {4'h1, el[i], 2'h0});
      tk(16'h1234, 1'b1, 1'b0, 1'b1);
      chk("oc pin", pin_out, ex[i]);
      chk("oc oe", pin_oe, {7'h00, el[i] != 2'h0});
    end
    rdc(`TPC_ADDR_STAT, 8'h02, "stat");
    wr_r(`TPC_ADDR_SC, 8'h10);
    // detach flag is registered from the new field, one cycle later
    @(posedge clk);
    #1;
    chk("det", pin_detached, 1'b1);
    chk("oe off", pin_oe, 1'b0);
    $display("test compare done");
  endtask

  task automatic t_pair;
    wr_r(`TPC_ADDR_VL, 8'h56);
    wr_r(`TPC_ADDR_SC, 8'h10);
    wr_r(`TPC_ADDR_VH, 8'h78);
    wr_r(`TPC_ADDR_VL, 8'h9A);
    rdc(`TPC_ADDR_VH, 8'h78, "vh");
    rdc(`TPC_ADDR_VL, 8'h9A, "vl");
    wr_r(`TPC_ADDR_VL, 8'hBC);
    rdc(`TPC_ADDR_VL, 8'h9A, "vl held");
    wr_r(`TPC_ADDR_VH, 8'hDE);
    rdc(`TPC_ADDR_VL, 8'hBC, "vl");
    rdc(`TPC_ADDR_VH, 8'hDE, "vh");
    $display("test pair done");
  endtask

  task automatic t_flag;
    wr_r(`TPC_ADDR_CLR, 8'h03);
    wr_r(`TPC_ADDR_SC, 8'h5C);
    tk(16'hDEBC, 1'b1, 1'b0, 1'b1);
    rdc(`TPC_ADDR_SC, 8'hDC, "flag");
    chk("irq on", irq, 1'b1);
    wr_r(`TPC_ADDR_SC, 8'hDC);
    rdc(`TPC_ADDR_SC, 8'hDC, "w1");
    wr_r(`TPC_ADDR_SC, 8'h5C);
    rdc(`TPC_ADDR_SC, 8'h5C, "clr");
    chk("irq off", irq, 1'b0);
    tk(16'hDEBC, 1'b1, 1'b0, 1'b1);
    rdc(`TPC_ADDR_SC, 8'hDC, "arm");
    tk(16'hDEBC, 1'b1, 1'b0, 1'b1);
    wr_r(`TPC_ADDR_SC, 8'h5C);
    rdc(`TPC_ADDR_SC, 8'hDC, "kept");
    wr_r(`TPC_ADDR_SC, 8'h1C);
    wr_r(`TPC_ADDR_EN, 8'h02);
    rdc(`TPC_ADDR_EN, 8'h02, "en");
    chk("irq en", irq, 1'b1);
    wr_r(`TPC_ADDR_CLR, 8'h02);
    rdc(`TPC_ADDR_STAT, 8'h00, "stat clr");
    chk("irq clr", irq, 1'b0);
    wr_r(`TPC_ADDR_EN, 8'h00);
    $display("test flag done");
  endtask

  task automatic t_cap;
    // drop the drive first so the pin is quiet when capture is chosen
    wr_r(`TPC_ADDR_SC, 8'h10);
    pin(1'b0, 16'hABCD);
    for (int e = 1; e < 4; e++) begin
      wr_r(`TPC_ADDR_SC, {4'h0, e[1:0], 2'h0});
      wr_r(`TPC_ADDR_CLR, 8'h03);
      pin(1'b1, 16'hABCD);
      rdc(`TPC_ADDR_STAT, {7'h00, e[0]}, "rise");
      wr_r(`TPC_ADDR_CLR, 8'h01);
      pin(1'b0, 16'hABCD);
      rdc(`TPC_ADDR_STAT, {7'h00, e[1]}, "fall");
    end
    pin(1'b1, 16'hABCD);
    rdc(`TPC_ADDR_VH, 8'hAB, "cap hi");
    pin(1'b0, 16'h1357);
    rdc(`TPC_ADDR_VL, 8'hCD, "frozen");
    rdc(`TPC_ADDR_VH, 8'h13, "live");
    wr_r(`TPC_ADDR_SC, 8'h0C);
    pin(1'b1, 16'h2468);
    rdc(`TPC_ADDR_VL, 8'h68, "released");
    $display("test capture done");
  endtask

  // ms bits vary on purpose: center mode must ignore them
  task automatic t_pwm;
    logic [7:0] sc [4] = '{8'h28, 8'h34, 8'h18, 8'h24};
    logic       a [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr_r(`TPC_ADDR_SC, 8'h28);
    wr_r(`TPC_ADDR_VH, 8'h00);
    wr_r(`TPC_ADDR_VL, 8'h40);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        @(posedge clk);
        cps <= 1'b1;
      end
      wr_r(`TPC_ADDR_SC, sc[i]);
      if (i < 2) tk(16'h0000, 1'b1, 1'b1, 1'b1);
      else tk(16'h0040, 1'b0, 1'b0, 1'b1);
      chk("pwm a", pin_out, a[i]);
      tk(16'h0040, 1'b1, 1'b0, 1'b1);
      chk("pwm b", pin_out, !a[i]);
      chk("pwm oe", pin_oe, 1'b1);
    end
    @(posedge clk);
    cps <= 1'b0;
    $display("test pwm done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // whole run is well under 1500 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    test_done;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cnt_value = 16'h0000;
    cnt_tick = 1'b0;
    cnt_wrap = 1'b0;
    cnt_up = 1'b1;
    cps = 1'b0;
    want = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_oc;
    t_pair;
    t_flag;
    t_cap;
    t_pwm;
    test_done;
  end
endmodule
